// file: hdl/sensor_port_pkg.sv
package sensor_port_pkg;
    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    localparam int unsigned START_BITS = 3;
    localparam int unsigned SETUP_BITS = 4;
    localparam int unsigned STOP_BITS = 3;
    localparam int unsigned FRAME_BITS = START_BITS + SETUP_BITS + STOP_BITS;
    localparam logic [9:0] FRAME_MASK = 10'h3ff;
    localparam logic [2:0] START_PAT = 3'h7;
    localparam logic [2:0] STOP_PAT = 3'h0;
    // setup codes (bit values not given; held as parameters)
    localparam logic [3:0] SETUP_PRESSURE = 4'ha;
    localparam logic [3:0] SETUP_TEMPERATURE = 4'h9;
    localparam logic [3:0] SETUP_CAL_FIRST = 4'h5;
    localparam logic [3:0] SETUP_CAL_SECOND = 4'h6;
    localparam logic [3:0] SETUP_CAL_THIRD = 4'h3;
    localparam logic [3:0] SETUP_CAL_FOURTH = 4'hc;
    // reset pattern, 21 bits, arbitrary default: sixteen alternating bits then five zeros
    localparam int unsigned RESET_BITS = 21;
    localparam logic [20:0] RESET_PAT = 21'h155540;
    // ------------------------------------------------------------
    // readout
    // ------------------------------------------------------------
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned READ_CLOCKS = 17;
    localparam int unsigned ACK_CLOCKS = 2;
    localparam logic [4:0] READ_CLOCKS_CNT = 5'h11;
    localparam logic [1:0] ACK_CLOCKS_CNT = 2'h2;
    // ------------------------------------------------------------
    // calibration coefficients, plain defaults
    // ------------------------------------------------------------
    localparam logic [12:0] COEFF_ONE_DEF = 13'h0a5c;
    localparam logic [12:0] COEFF_TWO_DEF = 13'h1234;
    localparam logic [9:0] COEFF_THREE_DEF = 10'h155;
    localparam logic [8:0] COEFF_FOUR_DEF = 9'h0aa;
    localparam logic [11:0] COEFF_FIVE_DEF = 12'h9c3;
    localparam logic [6:0] COEFF_SIX_DEF = 7'h2d;
    // conversion time in conversion clock periods (35 ms at 32.768 kHz)
    localparam int unsigned CONV_MCLK_CYCLES = 1147;
    localparam logic [10:0] CONV_MCLK_CNT = 11'h47b;
    // reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage

// file: hdl/calib_rom.sv
`timescale 1ns/10ps
`default_nettype none
module calib_rom
    import sensor_port_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // read port
    input wire logic [1:0] sel_i,
    output logic [15:0] data_o
);
    logic [15:0] words [4];

    // ------------------------------------------------------------
    // word packing
    // ------------------------------------------------------------
    // four words hold the six coefficients, msb first
    always_comb begin
        words[0] = {COEFF_ONE_DEF, COEFF_TWO_DEF[12:10]};
        words[1] = {COEFF_TWO_DEF[9:0], COEFF_FIVE_DEF[11:6]};
        words[2] = {COEFF_THREE_DEF, COEFF_FIVE_DEF[5:0]};
        words[3] = {COEFF_FOUR_DEF, COEFF_SIX_DEF};
    end

    // registered read data
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            data_o <= RESULT_RST;
        end else begin
            data_o <= words[sel_i];
        end
    end
endmodule
`default_nettype wire

// file: hdl/sensor_serial_port.sv
// What this block does
// - sample input bits and launch output bits on serial clock rising edge
// - frame is three high start bits, setup field, three low stop bits
// - four-bit setup picks pressure, temperature or one calibration word
// - output line carries selected data and also conversion status
// - conversion start is acknowledged by output going low to high
// - end of conversion is output going high to low
// - seventeen clocks read the sixteen-bit result out
// - readout pauses with the clock and resumes at same bit
// - a 21-bit reset pattern returns the port to idle from anywhere
// - sixty-four calibration bits as four readable sixteen-bit words
// - first and second word packing of coefficients one, two, five
// - third and fourth word packing of coefficients three to six
// - both results unsigned sixteen-bit from one shared converter
`timescale 1ns/10ps
`default_nettype none
module sensor_serial_port
    import sensor_port_pkg::*;
(
    // system
    input wire logic mclk_i,
    input wire logic nrst_i,
    // serial pins from host
    input wire logic sclk_i,
    input wire logic din_i,
    // serial output pin
    output logic dout_o,
    // conversion clock from host
    input wire logic conv_clk_i,
    // converter sample (analog front end stand-in)
    input wire logic [15:0] adc_pressure_i,
    input wire logic [15:0] adc_temperature_i,
    // status
    output logic busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACK = 3'b001,
        ST_CONV = 3'b010,
        ST_READ = 3'b011,
        ST_DONE = 3'b100
    } port_state_e;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_sync_ff, din_sync_ff, cclk_sync_ff;
    logic sclk_d_ff, cclk_d_ff, din_s;
    logic sclk_rise, cclk_rise;

    // two sync flops per pin, a third on sclk and conv_clk for edge detect; din uses the second
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            sclk_sync_ff <= 2'h0;
            din_sync_ff <= 2'h0;
            cclk_sync_ff <= 2'h0;
            sclk_d_ff <= 1'b0;
            cclk_d_ff <= 1'b0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], sclk_i};
            din_sync_ff <= {din_sync_ff[0], din_i};
            cclk_sync_ff <= {cclk_sync_ff[0], conv_clk_i};
            sclk_d_ff <= sclk_sync_ff[1];
            cclk_d_ff <= cclk_sync_ff[1];
        end
    end

    assign din_s = din_sync_ff[1];
    assign sclk_rise = sclk_sync_ff[1] & ~sclk_d_ff;
    assign cclk_rise = cclk_sync_ff[1] & ~cclk_d_ff;

    // ------------------------------------------------------------
    // input shift and pattern match
    // ------------------------------------------------------------
    logic [20:0] in_shift_ff;
    logic [20:0] nxt_in_shift;
    logic reset_hit, frame_hit;
    logic [3:0] setup_code;

    always_comb begin
        nxt_in_shift = {in_shift_ff[19:0], din_s};
    end

    // bits sampled on each serial rising edge
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            in_shift_ff <= 21'h0;
        end else if (sclk_rise) begin
            in_shift_ff <= nxt_in_shift;
        end
    end

    assign reset_hit = sclk_rise && (nxt_in_shift == RESET_PAT);
    assign frame_hit = sclk_rise && (nxt_in_shift[9:7] == START_PAT)
        && (nxt_in_shift[2:0] == STOP_PAT);
    assign setup_code = nxt_in_shift[6:3];

    // ------------------------------------------------------------
    // two-entry buffer between converter and readout
    // ------------------------------------------------------------
    logic [15:0] buf_data_ff [2];
    logic [1:0] buf_cnt_ff;
    logic buf_rd_ff, buf_wr_ff;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [15:0] buf_in_data;
    logic buf_push, buf_pop;

    assign buf_in_ready = (buf_cnt_ff != 2'h2);
    assign buf_out_valid = (buf_cnt_ff != 2'h0);
    assign buf_push = buf_in_valid & buf_in_ready;
    assign buf_pop = buf_out_valid & buf_out_ready;

    // small fifo so a stalled readout loses no result
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || reset_hit) begin
            buf_cnt_ff <= 2'h0;
            buf_rd_ff <= 1'b0;
            buf_wr_ff <= 1'b0;
            buf_data_ff[0] <= RESULT_RST;
            buf_data_ff[1] <= RESULT_RST;
        end else begin
            if (buf_push) begin
                buf_data_ff[buf_wr_ff] <= buf_in_data;
                buf_wr_ff <= ~buf_wr_ff;
            end
            if (buf_pop) begin
                buf_rd_ff <= ~buf_rd_ff;
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // ------------------------------------------------------------
    // converter timing on conversion clock rising edges
    // ------------------------------------------------------------
    port_state_e state_ff;
    logic [10:0] conv_cnt_ff;
    logic conv_temp_ff;
    logic conv_run_ff;
    logic conv_done;

    // one shared converter switched between pressure and temperature
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || reset_hit) begin
            conv_cnt_ff <= 11'h0;
            conv_run_ff <= 1'b0;
        end else if (state_ff == ST_ACK && !conv_run_ff) begin
            conv_cnt_ff <= 11'h0;
            conv_run_ff <= 1'b1;
        end else if (conv_run_ff && buf_push) begin
            conv_run_ff <= 1'b0;
        end else if (conv_run_ff && cclk_rise && conv_cnt_ff != CONV_MCLK_CNT) begin
            conv_cnt_ff <= conv_cnt_ff + 11'h1;
        end
    end

    assign conv_done = conv_run_ff && (conv_cnt_ff == CONV_MCLK_CNT);
    assign buf_in_valid = conv_done;
    assign buf_in_data = conv_temp_ff ? adc_temperature_i : adc_pressure_i;

    // ------------------------------------------------------------
    // calibration store
    // ------------------------------------------------------------
    logic [1:0] cal_sel_ff;
    logic [1:0] nxt_cal_sel, rom_sel;
    logic [15:0] cal_word;

    // setup field to word index
    always_comb begin
        case (setup_code)
            SETUP_CAL_SECOND: nxt_cal_sel = 2'h1;
            SETUP_CAL_THIRD: nxt_cal_sel = 2'h2;
            SETUP_CAL_FOURTH: nxt_cal_sel = 2'h3;
            default: nxt_cal_sel = 2'h0;
        endcase
    end

    // store read port has a register: address it from the decode while idle,
    // so the chosen word already stands when readout loads it
    assign rom_sel = (state_ff == ST_IDLE) ? nxt_cal_sel : cal_sel_ff;

    calib_rom u_calib_rom (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .sel_i(rom_sel),
        .data_o(cal_word)
    );

    // ------------------------------------------------------------
    // protocol state machine
    // ------------------------------------------------------------
    logic [4:0] bit_cnt_ff;
    logic [15:0] out_shift_ff;
    logic load_pending_ff;

    assign buf_out_ready = (state_ff == ST_CONV) && !conv_run_ff && load_pending_ff;

    // state, counters and output shifter
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || reset_hit) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 5'h0;
            out_shift_ff <= RESULT_RST;
            dout_o <= 1'b0;
            conv_temp_ff <= 1'b0;
            cal_sel_ff <= 2'h0;
            load_pending_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (frame_hit) begin
                        bit_cnt_ff <= 5'h0;
                        case (setup_code)
                            SETUP_PRESSURE, SETUP_TEMPERATURE: begin
                                conv_temp_ff <= (setup_code == SETUP_TEMPERATURE);
                                load_pending_ff <= 1'b1;
                                state_ff <= ST_ACK;
                            end
                            SETUP_CAL_FIRST, SETUP_CAL_SECOND,
                            SETUP_CAL_THIRD, SETUP_CAL_FOURTH: begin
                                cal_sel_ff <= nxt_cal_sel;
                                load_pending_ff <= 1'b1;
                                state_ff <= ST_READ;
                            end
                            default: begin
                                state_ff <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    dout_o <= 1'b1;
                    if (sclk_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 5'h1;
                        if (bit_cnt_ff[1:0] == ACK_CLOCKS_CNT - 2'h1) begin
                            state_ff <= ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    // output stays high until the converted word is taken
                    if (buf_pop) begin
                        out_shift_ff <= buf_data_ff[buf_rd_ff];
                        load_pending_ff <= 1'b0;
                        dout_o <= 1'b0;
                        bit_cnt_ff <= 5'h0;
                        state_ff <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (load_pending_ff) begin
                        out_shift_ff <= cal_word;
                        load_pending_ff <= 1'b0;
                    end else if (sclk_rise) begin
                        // pause simply holds position until the next edge
                        bit_cnt_ff <= bit_cnt_ff + 5'h1;
                        dout_o <= out_shift_ff[15];
                        out_shift_ff <= {out_shift_ff[14:0], 1'b0};
                        if (bit_cnt_ff == READ_CLOCKS_CNT - 5'h1) begin
                            state_ff <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    dout_o <= 1'b0;
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign busy_o = conv_run_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seq_ack_entered;
        state_ff == ST_ACK && !reset_hit;
    endsequence

    AST_RESET_IDLE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        reset_hit |=> state_ff == ST_IDLE)
        else $error("reset pattern did not return port to idle");
    AST_ACK_HIGH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        seq_ack_entered |=> dout_o)
        else $error("acknowledge did not raise output");
    AST_CONV_HOLDS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_ff == ST_CONV && $past(state_ff) == ST_CONV && !buf_pop) |-> dout_o)
        else $error("output fell before conversion end");
    AST_EOC_LOW: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_ff == ST_CONV && buf_pop && !reset_hit) |=> !dout_o && state_ff == ST_READ)
        else $error("end of conversion not signalled low");
    AST_READ_PAUSE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_ff == ST_READ && !load_pending_ff && !sclk_rise && !reset_hit)
        |=> $stable(bit_cnt_ff))
        else $error("readout moved without a clock edge");
    AST_READ_LEN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        state_ff == ST_READ |-> bit_cnt_ff < READ_CLOCKS_CNT)
        else $error("readout counted past seventeen clocks");
    AST_FRAME_START: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE && frame_hit && !reset_hit
         && setup_code == SETUP_PRESSURE) |=> state_ff == ST_ACK)
        else $error("framed conversion not accepted");
    AST_ACK_TWO: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_ff == ST_ACK && sclk_rise && bit_cnt_ff[1:0] == 2'h1 && !reset_hit)
        |=> state_ff == ST_CONV)
        else $error("conversion wait not entered after two clocks");
    AST_BUF_FULL: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        buf_in_valid |-> buf_in_ready)
        else $error("converted word refused by full buffer");
endmodule
`default_nettype wire

// file: bench/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
    import sensor_port_pkg::*;
(
    // pacing clock
    input wire logic mclk_i,
    // link pins
    output logic sclk_o,
    output logic din_o,
    output logic conv_clk_o,
    input wire logic dout_i
);
    // ----------------
    // conversion clock
    // ----------------
    logic conv_run;
    initial begin
        sclk_o = 1'b0;
        din_o = 1'b0;
        conv_clk_o = 1'b0;
        conv_run = 1'b0;
    end
    // six bench cycles a period; parked low while idle to save standby power
    always begin
        repeat (3) @(negedge mclk_i);
        conv_clk_o <= conv_run ? ~conv_clk_o : 1'b0;
    end
    // ----------------
    // serial link
    // ----------------
    // one clock of 200 ns; only the host makes it and it rests low
    task automatic pulse(input logic nxt);
        sclk_o = 1'b1;
        repeat (4) @(negedge mclk_i);
        sclk_o = 1'b0;
        din_o = nxt;
        repeat (4) @(negedge mclk_i);
    endtask
    // msb first; once the last hold is over din shows the inverse
    task automatic send_bits(input logic [20:0] bits, input int n);
        din_o = bits[n - 1];
        repeat (4) @(negedge mclk_i);
        for (int i = n - 1; i >= 0; i--) begin
            pulse((i > 0) ? bits[i - 1] : ~bits[0]);
        end
    endtask
    // start ones, setup code, stop zeros
    task automatic send_frame(input logic [3:0] code);
        send_bits({11'h000, START_PAT, code, STOP_PAT}, FRAME_BITS);
    endtask
    // output is not looked at while the pattern goes out
    task automatic send_reset();
        send_bits(RESET_PAT, RESET_BITS);
    endtask
    // capture at the end of the low phase: the output trails the pin by the sync delay
    task automatic read_word(input int pause_at, output logic [15:0] w, output logic tail);
        for (int k = 1; k <= 17; k++) begin
            pulse(1'b0);
            if (k == pause_at) begin
                repeat (37) @(negedge mclk_i);
            end
            if (k <= 16) begin
                w[16 - k] = dout_i;
            end else begin
                tail = dout_i;
            end
        end
    endtask
    // bounded wait for a level; n reaches limit if it never shows
    task automatic wait_dout(input logic lvl, input int limit, output int n);
        for (n = 0; n < limit; n++) begin
            @(negedge mclk_i);
            if (dout_i === lvl) begin
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import sensor_port_pkg::*;
;
    localparam int CYCLE_LIMIT = 50000;
    localparam int CONV_TICKS = 6 * CONV_MCLK_CYCLES;
    logic mclk, nrst_n, sclk, din, dout, conv_clk, busy;
    logic [15:0] adc_p, adc_t;
    logic [31:0] seed;
    logic [3:0] cal_codes [4];
    int miscompares, checked, cycles;
    // ----------------
    // design and host
    // ----------------
    sensor_serial_port i_dut (
        .mclk_i(mclk), .nrst_i(nrst_n), .sclk_i(sclk), .din_i(din), .dout_o(dout),
        .conv_clk_i(conv_clk), .adc_pressure_i(adc_p), .adc_temperature_i(adc_t),
        .busy_o(busy)
    );
    host_model i_host (
        .mclk_i(mclk), .sclk_o(sclk), .din_o(din), .conv_clk_o(conv_clk), .dout_i(dout)
    );
    // 40 MHz bench clock
    always #12.5 mclk = ~mclk;
    // hang guard, well above four conversions and the reads
    always @(posedge mclk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            miscompares++;
            $display("mismatch at %0t: run did not finish", $time);
            complete_run();
        end
    end
    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // packing of the six coefficients into four words
    function automatic logic [15:0] calib_word(input int idx);
        case (idx)
            0: return {COEFF_ONE_DEF, COEFF_TWO_DEF[12:10]};
            1: return {COEFF_TWO_DEF[9:0], COEFF_FIVE_DEF[11:6]};
            2: return {COEFF_THREE_DEF, COEFF_FIVE_DEF[5:0]};
            default: return {COEFF_FOUR_DEF, COEFF_SIX_DEF};
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic note(input string name);
        $display("test %s finished, %0d compares so far", name, checked);
    endtask
    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // frame plus readout of one calibration word
    task automatic read_cal(input int idx, input int pause_at);
        logic [15:0] w;
        logic tail;
        i_host.send_frame(cal_codes[idx]);
        i_host.read_word(pause_at, w, tail);
        check(w, calib_word(idx), "calibration word");
        check(tail, 1'b0, "bit after word");
    endtask
    // acknowledge, two clocks, clock held low, done, readout
    task automatic run_conv(input logic [3:0] code, input logic [15:0] exp, input int pause_at);
        int n;
        logic [15:0] w;
        logic tail;
        i_host.send_frame(code);
        i_host.wait_dout(1'b1, 20, n);
        check(n < 20, 1'b1, "acknowledge rise");
        i_host.pulse(1'b0);
        i_host.pulse(1'b0);
        check(busy, 1'b1, "busy while converting");
        i_host.conv_run = 1'b1;
        i_host.wait_dout(1'b0, CONV_TICKS + 40, n);
        check(n > CONV_TICKS - 12 && n < CONV_TICKS + 12, 1'b1, "conversion length");
        i_host.conv_run = 1'b0;
        check(busy, 1'b0, "busy after done");
        i_host.read_word(pause_at, w, tail);
        check(w, exp, "conversion result");
        check(tail, 1'b0, "bit after result");
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        int n;
        mclk = 1'b0;
        nrst_n = 1'b0;
        adc_p = 16'h0000;
        adc_t = 16'h0000;
        seed = 32'h2d75;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        cal_codes = '{SETUP_CAL_FIRST, SETUP_CAL_SECOND, SETUP_CAL_THIRD, SETUP_CAL_FOURTH};
        repeat (20) @(negedge mclk);
        nrst_n = 1'b1;
        @(negedge mclk);
        check(dout, 1'b0, "idle output");
        check(busy, 1'b0, "idle busy");
        // every word, then two with the clock stalled mid word and at its end
        for (int i = 0; i < 4; i++) begin
            read_cal(i, 0);
        end
        read_cal(2, 9);
        read_cal(1, 16);
        note("calibration");
        // an unknown setup code starts nothing
        i_host.send_frame(4'h0);
        i_host.wait_dout(1'b1, 40, n);
        check(n, 40, "unknown code ignored");
        read_cal(3, 0);
        note("unknown code");
        // random samples, reset before some frames, extreme values last
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            adc_p = (i == 3) ? 16'h0000 : seed[15:0];
            adc_t = (i == 3) ? 16'hffff : seed[31:16];
            if (i % 2 == 0) begin
                i_host.send_reset();
            end
            if (i % 2 == 1) begin
                run_conv(SETUP_TEMPERATURE, adc_t, 0);
            end else begin
                run_conv(SETUP_PRESSURE, adc_p, (i == 2) ? 5 : 0);
            end
        end
        note("conversions");
        // reset pattern in mid readout, then in mid conversion
        i_host.send_frame(SETUP_CAL_SECOND);
        for (int i = 0; i < 8; i++) begin
            i_host.pulse(1'b0);
        end
        i_host.send_reset();
        check(dout, 1'b0, "idle after reset in readout");
        read_cal(0, 0);
        i_host.send_frame(SETUP_PRESSURE);
        i_host.wait_dout(1'b1, 20, n);
        i_host.pulse(1'b0);
        i_host.pulse(1'b0);
        i_host.send_reset();
        check(busy, 1'b0, "busy after reset in conversion");
        check(dout, 1'b0, "idle after reset in conversion");
        read_cal(3, 0);
        note("reset pattern");
        // master reset while the acknowledge stands and the converter runs
        i_host.send_frame(SETUP_TEMPERATURE);
        i_host.wait_dout(1'b1, 20, n);
        i_host.pulse(1'b0);
        i_host.pulse(1'b0);
        nrst_n = 1'b0;
        repeat (4) @(negedge mclk);
        nrst_n = 1'b1;
        @(negedge mclk);
        check(dout, 1'b0, "output after master reset");
        @(negedge mclk);
        check(busy, 1'b0, "busy after master reset");
        read_cal(2, 0);
        note("master reset");
        complete_run();
    end
endmodule
`default_nettype wire
